/* File: rtl/ssrp_pkg.sv */
package ssrp_pkg;
   // ---------------------------------------------------------------
   // widths and reset values
   // ---------------------------------------------------------------
   localparam int          SSRP_DATA_W      = 32;
   localparam int          SSRP_ADDR_W      = 8;
   localparam int          SSRP_BE_W        = SSRP_DATA_W / 8;
   localparam int          SSRP_DEPTH       = 4;
   localparam int          SSRP_CNT_W       = 3;
   localparam logic        SSRP_FLAG_RST    = 1'b0;
   // strobes are active low, so idle is high
   localparam logic        SSRP_STROBE_IDLE = 1'b1;
   localparam logic [3:0]  SSRP_BE_IDLE     = 4'hf;
   // cycles of setup, with the read strobe already low, before the read state, and fixed wait states
   localparam logic [3:0]  SSRP_SETUP_CYC   = 4'h0;
   localparam logic [3:0]  SSRP_WAIT_CYC    = 4'h0;

   // ---------------------------------------------------------------
   // bus module state machine
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SSRP_IDLE  = 2'b00,
      SSRP_SETUP = 2'b01,
      SSRP_WAIT  = 2'b10,
      SSRP_READ  = 2'b11
   } ssrp_state_t;
endpackage

/* File: rtl/ssrp_if.sv */
`timescale 1ns/1ps
interface ssrp_if
   import ssrp_pkg::*;
();
   // ---------------------------------------------------------------
   // bus module to slave
   // ---------------------------------------------------------------
   logic                   chipselect;
   logic                   read_n;
   logic [SSRP_ADDR_W-1:0] address;
   logic [SSRP_BE_W-1:0]   byteenable_n;
   // ---------------------------------------------------------------
   // slave to bus module
   // ---------------------------------------------------------------
   logic [SSRP_DATA_W-1:0] readdata;
   logic                   dataavailable;
   logic                   readyfordata;
   logic                   endofpacket;
   logic                   waitrequest;

   modport slave (
      input  chipselect, read_n, address, byteenable_n,
      output readdata, dataavailable, readyfordata, endofpacket, waitrequest
   );
   modport busmod (
      output chipselect, read_n, address, byteenable_n,
      input  readdata, dataavailable, readyfordata, endofpacket, waitrequest
   );
endinterface

/* File: rtl/ssrp_slave.sv */
`timescale 1ns/1ps
module ssrp_slave
   import ssrp_pkg::*;
#(
   parameter int DEPTH = SSRP_DEPTH
) (
   // clock and reset
   input  wire logic                   i_clk,
   input  wire logic                   i_rst_n,
   // bus side
   ssrp_if.slave                       bus,
   // peripheral data source
   input  wire logic                   i_push,
   input  wire logic [SSRP_DATA_W-1:0] i_push_data,
   input  wire logic                   i_push_eop,
   input  wire logic                   i_eop_sticky,
   input  wire logic                   i_eop_clear,
   input  wire logic                   i_wr_ready,
   input  wire logic                   i_stall,
   output logic                        o_push_ready,
   output logic                        o_pop
);
   // ---------------------------------------------------------------
   // receive storage
   // ---------------------------------------------------------------
   logic [SSRP_DATA_W-1:0] mem_ff [DEPTH];
   logic                   eop_mem_ff [DEPTH];
   logic [SSRP_CNT_W-1:0]  wp_ff;
   logic [SSRP_CNT_W-1:0]  rp_ff;
   logic [SSRP_CNT_W-1:0]  cnt_ff;
   logic [SSRP_CNT_W-1:0]  nxt_cnt;
   logic                   rd_hit;
   logic                   pop;
   logic                   push;
   logic                   stall_ff;
   logic [SSRP_CNT_W-1:0]  nxt_rp;
   logic [SSRP_CNT_W-1:0]  remain;

   // a read beat completes on an edge where select is high, the low-active strobe is low and no stall
   assign rd_hit = bus.chipselect && !bus.read_n && !stall_ff;
   assign pop    = rd_hit && (cnt_ff != '0);
   assign push   = i_push && (cnt_ff != SSRP_CNT_W'(DEPTH));
   assign nxt_cnt = cnt_ff + SSRP_CNT_W'(push) - SSRP_CNT_W'(pop);
   // words still stored once this edge's pop is taken out
   assign remain  = cnt_ff - SSRP_CNT_W'(pop);
   assign nxt_rp  = !pop ? rp_ff : (rp_ff == SSRP_CNT_W'(DEPTH - 1)) ? '0 : rp_ff + 1'b1;

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_ff[wp_ff[$clog2(DEPTH)-1:0]]     <= i_push_data;
         eop_mem_ff[wp_ff[$clog2(DEPTH)-1:0]] <= i_push_eop;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wp_ff  <= '0;
         rp_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wp_ff <= (wp_ff == SSRP_CNT_W'(DEPTH - 1)) ? '0 : wp_ff + 1'b1;
         end
         rp_ff  <= nxt_rp;
         cnt_ff <= nxt_cnt;
      end
   end

   // ---------------------------------------------------------------
   // flow-control flags
   // ---------------------------------------------------------------
   logic dav_ff;
   logic rfd_ff;
   logic push_rdy_ff;
   logic pop_ff;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dav_ff <= SSRP_FLAG_RST;
      end else begin
         dav_ff <= (nxt_cnt != '0);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rfd_ff      <= SSRP_FLAG_RST;
         push_rdy_ff <= SSRP_FLAG_RST;
         pop_ff      <= 1'b0;
         stall_ff    <= 1'b0;
      end else begin
         rfd_ff      <= i_wr_ready;
         push_rdy_ff <= (nxt_cnt != SSRP_CNT_W'(DEPTH));
         pop_ff      <= pop;
         stall_ff    <= i_stall;
      end
   end

   // ---------------------------------------------------------------
   // read data and packet-end
   // ---------------------------------------------------------------
   logic [SSRP_DATA_W-1:0] rdata_ff;
   logic                   eop_ff;
   logic                   head_eop;

   // packet-end of the word that heads the store after this edge
   assign head_eop = (remain == '0) ? i_push_eop : eop_mem_ff[nxt_rp[$clog2(DEPTH)-1:0]];

   // fresh data
   // loads the next head, so back-to-back beats never see the same word twice
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_ff <= '0;
      end else if (remain != '0) begin
         rdata_ff <= mem_ff[nxt_rp[$clog2(DEPTH)-1:0]];
      end else if (push) begin
         rdata_ff <= i_push_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         eop_ff <= SSRP_FLAG_RST;
      end else if (nxt_cnt != '0 && head_eop) begin
         eop_ff <= 1'b1;
      end else if (!i_eop_sticky || i_eop_clear) begin
         eop_ff <= 1'b0;
      end
   end

   // presented data is the head word; a read removes it so the next is new
   // streaming port flags
   assign bus.readdata      = rdata_ff;
   assign bus.dataavailable = dav_ff;
   assign bus.readyfordata  = rfd_ff;
   assign bus.endofpacket   = eop_ff;
   assign bus.waitrequest   = stall_ff;
   assign o_push_ready      = push_rdy_ff;
   assign o_pop             = pop_ff;
endmodule

/* File: rtl/ssrp_busmod.sv */
`timescale 1ns/1ps
module ssrp_busmod
   import ssrp_pkg::*;
(
   // clock and reset
   input  wire logic                   i_clk,
   input  wire logic                   i_rst_n,
   // slave side
   ssrp_if.busmod                      bus,
   // streaming master side
   input  wire logic                   i_rd_req,
   input  wire logic [SSRP_ADDR_W-1:0] i_addr,
   input  wire logic [SSRP_BE_W-1:0]   i_be_n,
   output logic                        o_waitrequest,
   output logic                        o_rd_valid,
   output logic [SSRP_DATA_W-1:0]      o_rd_data,
   output logic                        o_eop
);
   ssrp_state_t            state_ff;
   logic [3:0]             cnt_ff;
   logic                   cs_ff;
   logic                   rd_n_ff;
   logic [SSRP_ADDR_W-1:0] addr_ff;
   logic [SSRP_BE_W-1:0]   be_n_ff;
   logic                   valid_ff;
   logic [SSRP_DATA_W-1:0] data_ff;
   logic                   eop_ff;
   logic                   go;
   logic                   beat;

   // a streaming request only starts a read while the slave offers data
   assign go   = i_rd_req && bus.dataavailable;
   // a word is only taken while the slave still offers one
   assign beat = (state_ff == SSRP_READ) && !bus.waitrequest && bus.dataavailable;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= SSRP_IDLE;
         cnt_ff   <= '0;
         cs_ff    <= 1'b0;
         rd_n_ff  <= SSRP_STROBE_IDLE;
         addr_ff  <= '0;
         be_n_ff  <= SSRP_BE_IDLE;
      end else begin
         case (state_ff)
            SSRP_IDLE: begin
               if (go) begin
                  cs_ff    <= 1'b1;
                  rd_n_ff  <= 1'b0;
                  addr_ff  <= i_addr;
                  be_n_ff  <= i_be_n;
                  cnt_ff   <= SSRP_SETUP_CYC;
                  state_ff <= (SSRP_SETUP_CYC != '0) ? SSRP_SETUP : SSRP_READ;
               end
            end
            SSRP_SETUP: begin
               cnt_ff <= cnt_ff - 4'h1;
               if (cnt_ff == 4'h1) begin
                  cnt_ff   <= SSRP_WAIT_CYC;
                  state_ff <= (SSRP_WAIT_CYC != '0) ? SSRP_WAIT : SSRP_READ;
               end
            end
            SSRP_WAIT: begin
               cnt_ff <= cnt_ff - 4'h1;
               if (cnt_ff == 4'h1) begin
                  state_ff <= SSRP_READ;
               end
            end
            SSRP_READ: begin
               if (!bus.dataavailable || (beat && !go)) begin
                  cs_ff    <= 1'b0;
                  rd_n_ff  <= SSRP_STROBE_IDLE;
                  be_n_ff  <= SSRP_BE_IDLE;
                  addr_ff  <= '0;
                  state_ff <= SSRP_IDLE;
               end else if (beat) begin
                  addr_ff <= i_addr;
                  be_n_ff <= i_be_n;
               end
            end
            default: begin
               state_ff <= SSRP_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         valid_ff <= 1'b0;
         data_ff  <= '0;
         eop_ff   <= 1'b0;
      end else begin
         valid_ff <= beat;
         eop_ff   <= bus.endofpacket;
         if (beat) begin
            data_ff <= bus.readdata;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_waitrequest <= 1'b1;
      end else begin
         o_waitrequest <= !go || bus.waitrequest;
      end
   end

   assign bus.chipselect   = cs_ff;
   assign bus.read_n       = rd_n_ff;
   assign bus.address      = addr_ff;
   assign bus.byteenable_n = be_n_ff;
   assign o_rd_valid       = valid_ff;
   assign o_rd_data        = data_ff;
   assign o_eop            = eop_ff;
endmodule

/* File: bench/ssrp_monitor.sv */
`timescale 1ns/1ps
module ssrp_monitor
   import ssrp_pkg::*;
(
   // clock and reset
   input wire logic                   i_clk,
   input wire logic                   i_rst_n,
   // interface signals
   input wire logic                   chipselect,
   input wire logic                   read_n,
   input wire logic [SSRP_ADDR_W-1:0] address,
   input wire logic [SSRP_BE_W-1:0]   byteenable_n,
   input wire logic [SSRP_DATA_W-1:0] readdata,
   input wire logic                   dataavailable,
   input wire logic                   readyfordata,
   input wire logic                   endofpacket,
   input wire logic                   waitrequest
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   logic beat;
   assign beat = chipselect && !read_n && !waitrequest && dataavailable;

   chk_start_gated: assert property ($rose(chipselect) |-> $past(dataavailable))
      else $error("select rose while no data was offered");
   chk_stay_idle: assert property (!dataavailable && !chipselect |=> !chipselect)
      else $error("read started while data-available low");
   chk_select_drop: assert property ($fell(dataavailable) |-> ##[0:2] !chipselect)
      else $error("select kept after data-available fell");
   chk_strobe_pair: assert property (chipselect |-> !read_n)
      else $error("select without read strobe");
   chk_flags_reset: assert property (disable iff (1'b0)
      !i_rst_n |-> !dataavailable && !readyfordata && !endofpacket)
      else $error("flag high during reset");
   chk_wait_holds: assert property (chipselect && waitrequest |=>
      chipselect && $stable(address) && $stable(byteenable_n))
      else $error("request changed during wait state");
   chk_fresh_data: assert property (beat ##1 beat |-> readdata != $past(readdata))
      else $error("repeated read data on successive beats");
   chk_master_end: assert property ($fell(chipselect) |-> read_n)
      else $error("strobe left low after select fell");

   // main scenarios seen
   cover property (beat ##1 beat);
   cover property (chipselect && waitrequest);
   cover property ($fell(chipselect) && dataavailable);
   cover property (beat && endofpacket);
endmodule

/* File: bench/streaming_slave_read_port_bench.sv */
`timescale 1ns/1ps
module streaming_slave_read_port_bench;
   import ssrp_pkg::*;
   typedef struct packed {
      logic [SSRP_DATA_W-1:0] din;
      logic                   eop;
   } ssrp_row_t;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic                   i_clk = 1'b0;
   logic                   i_rst_n, i_push, i_push_eop, i_eop_sticky, i_eop_clear;
   logic                   i_wr_ready, i_stall, i_rd_req;
   logic [SSRP_DATA_W-1:0] i_push_data;
   logic [SSRP_ADDR_W-1:0] i_addr;
   logic [SSRP_BE_W-1:0]   i_be_n;
   logic                   o_push_ready, o_pop, o_waitrequest, o_rd_valid, o_eop;
   logic [SSRP_DATA_W-1:0] o_rd_data;
   int                     err_total = 0;
   int                     samples_checked = 0;
   // read data comes back unchanged, so each row's input is also its expectation
   ssrp_row_t              rows [4] = '{'{32'h11110001, 1'b0}, '{32'h22220002, 1'b1},
                                        '{32'h33330003, 1'b0}, '{32'h44440004, 1'b1}};
   always #50 i_clk = ~i_clk;
   ssrp_if ifc ();
   ssrp_slave #(.DEPTH(4)) ssrp_slave_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(ifc),
      .i_push(i_push), .i_push_data(i_push_data), .i_push_eop(i_push_eop),
      .i_eop_sticky(i_eop_sticky), .i_eop_clear(i_eop_clear), .i_wr_ready(i_wr_ready),
      .i_stall(i_stall), .o_push_ready(o_push_ready), .o_pop(o_pop));
   ssrp_busmod ssrp_busmod_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(ifc),
      .i_rd_req(i_rd_req), .i_addr(i_addr), .i_be_n(i_be_n), .o_waitrequest(o_waitrequest),
      .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_eop(o_eop));
   ssrp_monitor ssrp_monitor_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .chipselect(ifc.chipselect), .read_n(ifc.read_n), .address(ifc.address),
      .byteenable_n(ifc.byteenable_n), .readdata(ifc.readdata),
      .dataavailable(ifc.dataavailable), .readyfordata(ifc.readyfordata),
      .endofpacket(ifc.endofpacket), .waitrequest(ifc.waitrequest));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk_w(input logic [SSRP_DATA_W-1:0] got, input logic [SSRP_DATA_W-1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_b(input logic got, input logic exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s is %b", $time, what, got);
      end
   endtask
   task automatic push(input logic [SSRP_DATA_W-1:0] d, input logic e);
      @(negedge i_clk);
      i_push = 1'b1;
      i_push_data = d;
      i_push_eop = e;
      @(negedge i_clk);
      i_push = 1'b0;
   endtask
   // waits a bounded time for one returned word, then checks word and packet-end
   task automatic get(input logic [SSRP_DATA_W-1:0] d, input logic e);
      bit ok;
      ok = 1'b0;
      for (int n = 0; n < 20 && !ok; n++) begin
         @(negedge i_clk);
         ok = (o_rd_valid === 1'b1);
      end
      if (!ok) begin
         err_total++;
         $display("[FAIL] %0t no read data returned", $time);
         final_report();
      end
      chk_w(o_rd_data, d);
      chk_b(o_eop, e, "eop");
   endtask
   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      {i_rst_n, i_push, i_push_eop, i_eop_sticky, i_eop_clear} = 5'h0;
      {i_wr_ready, i_stall, i_rd_req} = 3'h0;
      i_push_data = 32'h0;
      i_addr = 8'h10;
      i_be_n = 4'h0;
      repeat (4) @(negedge i_clk);
      chk_b(ifc.dataavailable, 1'b0, "avail");
      chk_b(ifc.chipselect, 1'b0, "select");
      chk_b(o_waitrequest, 1'b1, "wait");
      i_rst_n = 1'b1;
      i_wr_ready = 1'b1;
      @(negedge i_clk);
      chk_b(ifc.readyfordata, 1'b1, "ready");
      $display("reset test done");
      for (int k = 0; k < 4; k++) push(rows[k].din, rows[k].eop);
      chk_b(ifc.dataavailable, 1'b1, "avail");
      chk_b(o_push_ready, 1'b0, "push ready");
      i_rd_req = 1'b1;
      for (int k = 0; k < 4; k++) get(rows[k].din, rows[k].eop);
      repeat (3) @(negedge i_clk);
      chk_b(ifc.dataavailable, 1'b0, "avail");
      chk_b(ifc.chipselect, 1'b0, "select");
      chk_b(o_waitrequest, 1'b1, "wait");
      $display("row test done");
      push(32'h5a5a0001, 1'b0);
      get(32'h5a5a0001, 1'b0);
      i_stall = 1'b1;
      push(32'h5a5a0002, 1'b0);
      repeat (4) @(negedge i_clk);
      chk_b(ifc.chipselect, 1'b1, "select");
      chk_b(o_waitrequest, 1'b1, "wait");
      i_stall = 1'b0;
      get(32'h5a5a0002, 1'b0);
      $display("stall test done");
      i_eop_sticky = 1'b1;
      push(32'h5a5a0003, 1'b1);
      get(32'h5a5a0003, 1'b1);
      repeat (3) @(negedge i_clk);
      chk_b(ifc.endofpacket, 1'b1, "held eop");
      i_eop_clear = 1'b1;
      @(negedge i_clk);
      i_eop_clear = 1'b0;
      @(negedge i_clk);
      chk_b(ifc.endofpacket, 1'b0, "cleared eop");
      $display("packet-end test done");
      i_rd_req = 1'b0;
      for (int k = 0; k < 4; k++) push(rows[k].din, 1'b0);
      i_rd_req = 1'b1;
      get(rows[0].din, 1'b0);
      chk_b(o_pop, 1'b1, "pop");
      i_rd_req = 1'b0;
      i_wr_ready = 1'b0;
      repeat (3) @(negedge i_clk);
      chk_b(ifc.chipselect, 1'b0, "select");
      chk_b(ifc.dataavailable, 1'b1, "avail");
      chk_b(ifc.readyfordata, 1'b0, "ready low");
      $display("master end test done");
      final_report();
   end
endmodule
